//--- design/psia_top.sv
// port status latching, summary word and interrupt aggregation
module psia_top (
	CLK,
	RST_N,
	ADDR,
	CS_N,
	WR_N,
	RD_N,
	WDATA,
	RDATA,
	TRAIL_TRACE_IRQ,
	FAR_END_CODE_IRQ,
	LINK_CTRL_IRQ,
	PATTERN_TESTER_IRQ,
	FRAMER_DS3_IRQ,
	FRAMER_E3_IRQ,
	FRAMER_E3_MODE,
	LINE_CODE_IRQ,
	TX_DRIVER_OVERLOAD,
	RX_LOCK_LOSS,
	PERF_UPDATE_STATUS,
	RX_LINE_CLK_PIN,
	RX_RECOVERED_CLK,
	TX_INPUT_CLK_PIN,
	PORT_GLOBAL_IRQ_ENABLE,
	DATAPATH_SOFT_RESET_GLOBAL,
	DATAPATH_SOFT_RESET_PORT,
	PORT_POWER_DOWN,
	PATTERN_TESTER_CLEAR,
	IRQ
);
	parameter int PORT_IDX = 0;
	parameter int N_PERF = 4;
	input wire logic CLK; // system clock
	input wire logic RST_N; // async reset, active low
	input wire logic [7:0] ADDR; // register byte address
	input wire logic CS_N; // chip select, active low
	input wire logic WR_N; // write strobe, active low, one cycle
	input wire logic RD_N; // read strobe, active low
	input wire logic [15:0] WDATA; // write data
	output logic [15:0] RDATA; // registered read data
	input wire logic TRAIL_TRACE_IRQ; // enabled latch pending in trail trace
	input wire logic FAR_END_CODE_IRQ; // enabled latch pending in far-end code
	input wire logic LINK_CTRL_IRQ; // enabled latch pending in link controller
	input wire logic PATTERN_TESTER_IRQ; // enabled latch pending in pattern tester
	input wire logic FRAMER_DS3_IRQ; // enabled latch pending in ds3 framer
	input wire logic FRAMER_E3_IRQ; // enabled latch pending in e3 framer
	input wire logic FRAMER_E3_MODE; // 1 selects the e3 framer
	input wire logic LINE_CODE_IRQ; // enabled latch pending in line coder
	input wire logic TX_DRIVER_OVERLOAD; // driver monitor, async
	input wire logic RX_LOCK_LOSS; // clock recovery unlocked, async
	input wire logic [N_PERF-1:0] PERF_UPDATE_STATUS; // per-counter done
	input wire logic RX_LINE_CLK_PIN; // receive line clock pin
	input wire logic RX_RECOVERED_CLK; // recovered clock
	input wire logic TX_INPUT_CLK_PIN; // transmit input clock pin
	input wire logic PORT_GLOBAL_IRQ_ENABLE; // this port's global enable
	input wire logic DATAPATH_SOFT_RESET_GLOBAL; // global datapath reset
	input wire logic DATAPATH_SOFT_RESET_PORT; // port datapath reset
	input wire logic PORT_POWER_DOWN; // port power-down
	output logic PATTERN_TESTER_CLEAR; // clears pattern tester regs
	output logic IRQ; // interrupt, active high

	logic [N_PERF+1:0] live_sync;
	logic [2:0] clk_sync;
	logic rx_line_act, rx_rec_act, tx_act;
	logic [2:0] live_q;
	logic [2:0] live_prev_q;
	logic [15:0] latched_q;
	logic [15:0] latched_d;
	logic [15:0] irq_en_q;
	logic [15:0] summary;
	logic perf_and;
	logic wr_stb;
	logic rd_stb;
	logic port_pending;

	// register hit; shared by the write decodes, while the read decode uses a case on ADDR
	function automatic logic reg_hit(input logic stb, input logic [7:0] a,
			input logic [7:0] t);
		return stb && (a == t);
	endfunction

	// pins pass two flops before any logic; the update AND comes after them
	psia_sync #(.W(N_PERF + 2)) u_sync_live (
		.CLK(CLK),
		.RST_N(RST_N),
		.d({TX_DRIVER_OVERLOAD, RX_LOCK_LOSS, PERF_UPDATE_STATUS}),
		.q(live_sync)
	);
	psia_sync #(.W(3)) u_sync_clk (
		.CLK(CLK),
		.RST_N(RST_N),
		.d({RX_LINE_CLK_PIN, RX_RECOVERED_CLK, TX_INPUT_CLK_PIN}),
		.q(clk_sync)
	);
	psia_clk_act u_act_rxl (
		.CLK(CLK),
		.RST_N(RST_N),
		.clk_sync(clk_sync[2]),
		.active(rx_line_act)
	);
	psia_clk_act u_act_rxr (
		.CLK(CLK),
		.RST_N(RST_N),
		.clk_sync(clk_sync[1]),
		.active(rx_rec_act)
	);
	psia_clk_act u_act_tx (
		.CLK(CLK),
		.RST_N(RST_N),
		.clk_sync(clk_sync[0]),
		.active(tx_act)
	);

	assign perf_and = &live_sync[N_PERF-1:0];
	assign wr_stb = !CS_N && !WR_N;
	assign rd_stb = !CS_N && !RD_N;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			live_q <= 3'h0;
			live_prev_q <= 3'h0;
		end else begin
			live_q[psia_pkg::B_OVERLOAD] <= live_sync[N_PERF + 1];
			live_q[psia_pkg::B_LOCK_LOSS] <= live_sync[N_PERF];
			live_q[psia_pkg::B_UPD_DONE] <= perf_and;
			live_prev_q <= live_q;
		end
	end

	a_ovl_live: assert property (@(posedge CLK) disable iff (!RST_N)
		live_q[psia_pkg::B_OVERLOAD] == $past(live_sync[N_PERF + 1]))
		else $error("overload live bit does not follow its pin");
	a_lock_live: assert property (@(posedge CLK) disable iff (!RST_N)
		live_q[psia_pkg::B_LOCK_LOSS] == $past(live_sync[N_PERF]))
		else $error("lock loss live bit does not follow its pin");
	a_upd_fall: assert property (@(posedge CLK) disable iff (!RST_N)
		$fell(perf_and) |=> !live_q[psia_pkg::B_UPD_DONE])
		else $error("update done stays set after a counter restarts");

	// set wins over a write-one clear in the same cycle
	always_comb begin
		latched_d = latched_q;
		if (reg_hit(wr_stb, ADDR, psia_pkg::ADDR_LATCHED))
			latched_d = latched_q & ~(WDATA & psia_pkg::LATCH_MASK);
		for (int i = 0; i < 3; i++) begin
			if (live_q[i] && !live_prev_q[i])
				latched_d[i] = 1'b1;
		end
		if (rx_line_act || rx_rec_act)
			latched_d[psia_pkg::B_RX_CLK_ACT] = 1'b1;
		if (tx_act)
			latched_d[psia_pkg::B_TX_CLK_ACT] = 1'b1;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			latched_q <= 16'h0000;
		else
			latched_q <= latched_d;
	end

	a_ovl_rise: assert property (@(posedge CLK) disable iff (!RST_N)
		(live_q[psia_pkg::B_OVERLOAD] && !live_prev_q[psia_pkg::B_OVERLOAD])
		|=> latched_q[psia_pkg::B_OVERLOAD])
		else $error("overload edge not latched");
	a_upd_rise: assert property (@(posedge CLK) disable iff (!RST_N)
		(live_q[psia_pkg::B_UPD_DONE] && !live_prev_q[psia_pkg::B_UPD_DONE])
		|=> latched_q[psia_pkg::B_UPD_DONE])
		else $error("update done edge not latched");
	a_ovl_level: assert property (@(posedge CLK) disable iff (!RST_N)
		(!latched_q[psia_pkg::B_OVERLOAD] && live_prev_q[psia_pkg::B_OVERLOAD])
		|=> !latched_q[psia_pkg::B_OVERLOAD])
		else $error("overload latch set by a level");
	a_lock_level: assert property (@(posedge CLK) disable iff (!RST_N)
		(!latched_q[psia_pkg::B_LOCK_LOSS] && live_prev_q[psia_pkg::B_LOCK_LOSS])
		|=> !latched_q[psia_pkg::B_LOCK_LOSS])
		else $error("lock loss latch set by a level");
	a_clear_w1: assert property (@(posedge CLK) disable iff (!RST_N)
		(reg_hit(wr_stb, ADDR, psia_pkg::ADDR_LATCHED) && WDATA[psia_pkg::B_LOCK_LOSS]
		&& !(live_q[psia_pkg::B_LOCK_LOSS] && !live_prev_q[psia_pkg::B_LOCK_LOSS]))
		|=> !latched_q[psia_pkg::B_LOCK_LOSS])
		else $error("write one did not clear the lock loss latch");
	a_lock_hold: assert property (@(posedge CLK) disable iff (!RST_N)
		(latched_q[psia_pkg::B_LOCK_LOSS] && !reg_hit(wr_stb, ADDR, psia_pkg::ADDR_LATCHED))
		|=> latched_q[psia_pkg::B_LOCK_LOSS])
		else $error("lock loss latch dropped without clear");
	a_rx_hold: assert property (@(posedge CLK) disable iff (!RST_N)
		(latched_q[psia_pkg::B_RX_CLK_ACT] && !reg_hit(wr_stb, ADDR, psia_pkg::ADDR_LATCHED))
		|=> latched_q[psia_pkg::B_RX_CLK_ACT])
		else $error("rx activity latch dropped without clear");
	a_rx_act: assert property (@(posedge CLK) disable iff (!RST_N)
		(rx_line_act || rx_rec_act) |=> latched_q[psia_pkg::B_RX_CLK_ACT])
		else $error("rx clock activity not latched");
	a_latch_rsvd: assert property (@(posedge CLK) disable iff (!RST_N)
		(latched_q & ~psia_pkg::LATCH_MASK) == 16'h0000)
		else $error("unused latched bit set");

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			irq_en_q <= psia_pkg::IRQ_EN_RESET;
		else if (reg_hit(wr_stb, ADDR, psia_pkg::ADDR_IRQ_EN))
			irq_en_q <= WDATA & psia_pkg::IE_MASK;
	end

	a_en_write: assert property (@(posedge CLK) disable iff (!RST_N)
		reg_hit(wr_stb, ADDR, psia_pkg::ADDR_IRQ_EN)
		|=> irq_en_q == $past(WDATA & psia_pkg::IE_MASK))
		else $error("enable write not stored");
	a_en_keep: assert property (@(posedge CLK) disable iff (!RST_N)
		!reg_hit(wr_stb, ADDR, psia_pkg::ADDR_IRQ_EN) |=> $stable(irq_en_q))
		else $error("enable changed without a write");
	a_en_rsvd: assert property (@(posedge CLK) disable iff (!RST_N)
		(irq_en_q & ~psia_pkg::IE_MASK) == 16'h0000)
		else $error("unused enable bit set");

	// summary is combinational so it falls as soon as sources clear
	assign port_pending = |(latched_q & irq_en_q & psia_pkg::IE_MASK);
	always_comb begin
		summary = 16'h0000;
		summary[psia_pkg::S_PORT] = port_pending;
		summary[psia_pkg::S_LINE_CODE] = LINE_CODE_IRQ;
		summary[psia_pkg::S_TRAIL] = TRAIL_TRACE_IRQ;
		summary[psia_pkg::S_FEAC] = FAR_END_CODE_IRQ;
		summary[psia_pkg::S_LINK] = LINK_CTRL_IRQ;
		summary[psia_pkg::S_PATTERN] = PATTERN_TESTER_IRQ;
		summary[psia_pkg::S_FRAMER] = FRAMER_E3_MODE ? FRAMER_E3_IRQ : FRAMER_DS3_IRQ;
	end

	a_trail_sum: assert property (@(posedge CLK) disable iff (!RST_N)
		summary[psia_pkg::S_TRAIL] == TRAIL_TRACE_IRQ)
		else $error("trail trace summary wrong");
	a_feac_sum: assert property (@(posedge CLK) disable iff (!RST_N)
		summary[psia_pkg::S_FEAC] == FAR_END_CODE_IRQ)
		else $error("far-end code summary wrong");
	a_link_sum: assert property (@(posedge CLK) disable iff (!RST_N)
		summary[psia_pkg::S_LINK] == LINK_CTRL_IRQ)
		else $error("link control summary wrong");
	a_pattern_sum: assert property (@(posedge CLK) disable iff (!RST_N)
		summary[psia_pkg::S_PATTERN] == PATTERN_TESTER_IRQ)
		else $error("pattern tester summary wrong");
	a_ds3_sel: assert property (@(posedge CLK) disable iff (!RST_N)
		!FRAMER_E3_MODE |-> summary[psia_pkg::S_FRAMER] == FRAMER_DS3_IRQ)
		else $error("framer summary wrong source in ds3 mode");
	a_line_sum: assert property (@(posedge CLK) disable iff (!RST_N)
		summary[psia_pkg::S_LINE_CODE] == LINE_CODE_IRQ)
		else $error("line code summary wrong");
	a_port_off: assert property (@(posedge CLK) disable iff (!RST_N)
		(irq_en_q & psia_pkg::IE_MASK) == 16'h0000 |-> !summary[psia_pkg::S_PORT])
		else $error("port summary set with no enable");
	a_sum_rsvd: assert property (@(posedge CLK) disable iff (!RST_N)
		(summary >> (psia_pkg::S_PORT + 1)) == 16'h0000
		&& summary[psia_pkg::S_PATTERN - 1:psia_pkg::S_FRAMER + 1] == 3'h0)
		else $error("reserved summary bit set");

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			IRQ <= 1'b0;
		else
			IRQ <= (|summary) && PORT_GLOBAL_IRQ_ENABLE;
	end

	a_irq_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
		!(|summary) |=> !IRQ)
		else $error("interrupt with no summary bit");
	a_irq_port: assert property (@(posedge CLK) disable iff (!RST_N)
		((|(latched_q & irq_en_q)) && PORT_GLOBAL_IRQ_ENABLE) |=> IRQ)
		else $error("enabled latched bit gave no interrupt");

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			PATTERN_TESTER_CLEAR <= 1'b1;
		else
			PATTERN_TESTER_CLEAR <= DATAPATH_SOFT_RESET_GLOBAL || DATAPATH_SOFT_RESET_PORT
				|| PORT_POWER_DOWN;
	end

	a_pt_glob: assert property (@(posedge CLK) disable iff (!RST_N)
		DATAPATH_SOFT_RESET_GLOBAL |=> PATTERN_TESTER_CLEAR)
		else $error("pattern tester not cleared by global reset");
	a_pt_port: assert property (@(posedge CLK) disable iff (!RST_N)
		DATAPATH_SOFT_RESET_PORT |=> PATTERN_TESTER_CLEAR)
		else $error("pattern tester not cleared by port reset");
	a_pt_release: assert property (@(posedge CLK) disable iff (!RST_N)
		!(DATAPATH_SOFT_RESET_GLOBAL || DATAPATH_SOFT_RESET_PORT || PORT_POWER_DOWN)
		|=> !PATTERN_TESTER_CLEAR)
		else $error("pattern tester clear stuck");

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= 16'h0000;
		end else if (rd_stb) begin
			case (ADDR)
				psia_pkg::ADDR_SUMMARY: RDATA <= summary;
				psia_pkg::ADDR_LIVE: RDATA <= {13'h0, live_q};
				psia_pkg::ADDR_LATCHED: RDATA <= latched_q;
				psia_pkg::ADDR_IRQ_EN: RDATA <= irq_en_q;
				default: RDATA <= 16'h0000;
			endcase
		end
	end

	a_sum_read: assert property (@(posedge CLK) disable iff (!RST_N)
		reg_hit(rd_stb, ADDR, psia_pkg::ADDR_SUMMARY) |=> RDATA == $past(summary))
		else $error("summary read wrong");
	a_live_read: assert property (@(posedge CLK) disable iff (!RST_N)
		reg_hit(rd_stb, ADDR, psia_pkg::ADDR_LIVE) |=> RDATA == {13'h0, $past(live_q)})
		else $error("live status read wrong");
	a_latch_read: assert property (@(posedge CLK) disable iff (!RST_N)
		reg_hit(rd_stb, ADDR, psia_pkg::ADDR_LATCHED) |=> RDATA == $past(latched_q))
		else $error("latched status read wrong");
	a_rd_hold: assert property (@(posedge CLK) disable iff (!RST_N)
		!rd_stb |=> $stable(RDATA))
		else $error("read data changed without a read");

	// host keeps the update request high until done reads one; not checked here

	a_latch_rise: assert property (@(posedge CLK) disable iff (!RST_N)
		(live_q[psia_pkg::B_LOCK_LOSS] && !live_prev_q[psia_pkg::B_LOCK_LOSS])
		|=> latched_q[psia_pkg::B_LOCK_LOSS])
		else $error("lock loss edge not latched");
	a_latch_hold: assert property (@(posedge CLK) disable iff (!RST_N)
		(latched_q[psia_pkg::B_OVERLOAD] && !(wr_stb && ADDR == psia_pkg::ADDR_LATCHED))
		|=> latched_q[psia_pkg::B_OVERLOAD])
		else $error("latched bit dropped without clear");
	a_irq_follow: assert property (@(posedge CLK) disable iff (!RST_N)
		((|summary) && PORT_GLOBAL_IRQ_ENABLE) |=> IRQ)
		else $error("interrupt not raised");
	a_irq_gate: assert property (@(posedge CLK) disable iff (!RST_N)
		!PORT_GLOBAL_IRQ_ENABLE |=> !IRQ)
		else $error("interrupt without global enable");
	a_port_sum: assert property (@(posedge CLK) disable iff (!RST_N)
		summary[psia_pkg::S_PORT] == |(latched_q[2:0] & irq_en_q[2:0]))
		else $error("port summary mismatch");
	a_framer_sel: assert property (@(posedge CLK) disable iff (!RST_N)
		FRAMER_E3_MODE |-> summary[psia_pkg::S_FRAMER] == FRAMER_E3_IRQ)
		else $error("framer summary wrong source");
	a_pt_clear: assert property (@(posedge CLK) disable iff (!RST_N)
		PORT_POWER_DOWN |=> PATTERN_TESTER_CLEAR)
		else $error("pattern tester not cleared");
	a_tx_act: assert property (@(posedge CLK) disable iff (!RST_N)
		tx_act |=> latched_q[psia_pkg::B_TX_CLK_ACT])
		else $error("tx clock activity not latched");
	a_upd_live: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(perf_and) |=> live_q[psia_pkg::B_UPD_DONE])
		else $error("update done not reported");
endmodule

//--- design/psia_pkg.sv
// constants for the port status and interrupt aggregator
package psia_pkg;
	localparam logic [7:0] ADDR_SUMMARY = 8'h50;
	localparam logic [7:0] ADDR_LIVE = 8'h52;
	localparam logic [7:0] ADDR_LATCHED = 8'h54;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h56;
	localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
	localparam int B_OVERLOAD = 2;
	localparam int B_LOCK_LOSS = 1;
	localparam int B_UPD_DONE = 0;
	localparam int B_RX_CLK_ACT = 7;
	localparam int B_TX_CLK_ACT = 6;
	localparam int S_PORT = 9;
	localparam int S_LINE_CODE = 8;
	localparam int S_TRAIL = 7;
	localparam int S_FEAC = 6;
	localparam int S_LINK = 5;
	localparam int S_PATTERN = 4;
	localparam int S_FRAMER = 0;
	localparam logic [15:0] LATCH_MASK = 16'h00C7;
	localparam logic [15:0] IE_MASK = 16'h0007;
endpackage

//--- design/psia_sync.sv
// two-stage synchroniser for pin-level inputs
module psia_sync #(
	parameter int W = 1
) (
	input wire logic CLK, // system clock
	input wire logic RST_N, // async reset, active low
	input wire logic [W-1:0] d, // asynchronous input
	output logic [W-1:0] q // synchronised output
);
	logic [W-1:0] meta_q;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

//--- design/psia_clk_act.sv
// clock activity detector: toggle of a sampled clock between two consecutive samples
module psia_clk_act (
	input wire logic CLK, // system clock
	input wire logic RST_N, // async reset, active low
	input wire logic clk_sync, // line clock already synchronised
	output logic active // one-cycle pulse on observed edge
);
	logic prev_q;
	// a sampled clock that changes level is running; slow enough clocks only
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			prev_q <= 1'b0;
			active <= 1'b0;
		end else begin
			prev_q <= clk_sync;
			active <= clk_sync ^ prev_q;
		end
	end
endmodule

//--- tb/psia_host.sv
// host bus model for the port register interface
module psia_host (
	input wire logic clk, // system clock
	input wire logic [15:0] rdata, // read data from block
	output logic [7:0] addr, // register address
	output logic cs_n, // chip select, active low
	output logic wr_n, // write strobe, active low
	output logic rd_n, // read strobe, active low
	output logic [15:0] wdata // write data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		addr = 8'h00;
		wdata = 16'h0000;
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
	end
	// one-cycle strobe; a one written to the latched register clears that latch
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		cs_n = 1'b0;
		wr_n = 1'b0;
		@(posedge clk);
		#1;
		cs_n = 1'b1;
		wr_n = 1'b1;
		// released bus shows no stale value
		wdata = ~d;
		addr = ~a;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		#1;
		addr = a;
		cs_n = 1'b0;
		rd_n = 1'b0;
		@(posedge clk);
		#1;
		d = rdata;
		cs_n = 1'b1;
		rd_n = 1'b1;
		addr = ~a;
	endtask
endmodule

//--- tb/psia_top_tb.sv
// self-checking bench for the port status aggregator
module psia_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr;
	logic cs_n;
	logic wr_n;
	logic rd_n;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] v;
	logic [6:0] src = 7'h00;
	logic e3m = 1'b0;
	logic ovl = 1'b0;
	logic lock = 1'b0;
	logic [3:0] perf = 4'h0;
	logic [2:0] clks = 3'h0;
	logic gie = 1'b0;
	logic [2:0] ctl = 3'h0;
	logic ptc;
	logic irq;
	int fail_count = 0;
	int check_count = 0;
	int sb[7] = '{8, 7, 6, 5, 4, 0, 0};
	always #5 clk = ~clk;
	psia_host psia_host_inst (.clk(clk), .rdata(rdata), .addr(addr), .cs_n(cs_n),
		.wr_n(wr_n), .rd_n(rd_n), .wdata(wdata));
	psia_top psia_top_inst (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .CS_N(cs_n),
		.WR_N(wr_n), .RD_N(rd_n), .WDATA(wdata), .RDATA(rdata),
		.LINE_CODE_IRQ(src[0]), .TRAIL_TRACE_IRQ(src[1]), .FAR_END_CODE_IRQ(src[2]),
		.LINK_CTRL_IRQ(src[3]), .PATTERN_TESTER_IRQ(src[4]), .FRAMER_DS3_IRQ(src[5]),
		.FRAMER_E3_IRQ(src[6]), .FRAMER_E3_MODE(e3m), .TX_DRIVER_OVERLOAD(ovl),
		.RX_LOCK_LOSS(lock), .PERF_UPDATE_STATUS(perf), .RX_LINE_CLK_PIN(clks[0]),
		.RX_RECOVERED_CLK(clks[1]), .TX_INPUT_CLK_PIN(clks[2]),
		.PORT_GLOBAL_IRQ_ENABLE(gie), .DATAPATH_SOFT_RESET_GLOBAL(ctl[0]),
		.DATAPATH_SOFT_RESET_PORT(ctl[1]), .PORT_POWER_DOWN(ctl[2]),
		.PATTERN_TESTER_CLEAR(ptc), .IRQ(irq));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		psia_host_inst.rd(a, v);
		chk(v, exp);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		wt(2);
		chk({15'h0, ptc}, 16'h0000);
		rchk(psia_pkg::ADDR_IRQ_EN, psia_pkg::IRQ_EN_RESET);
		rchk(psia_pkg::ADDR_LATCHED, 16'h0000);
		$display("test reset values done");
		gie = 1'b1;
		for (int i = 0; i < 7; i++) begin
			src = 7'h01 << i;
			e3m = (i == 6);
			wt(3);
			rchk(psia_pkg::ADDR_SUMMARY, 16'h0001 << sb[i]);
			chk({15'h0, irq}, 16'h0001);
		end
		src = 7'h20;
		wt(3);
		rchk(psia_pkg::ADDR_SUMMARY, 16'h0000);
		gie = 1'b0;
		src = 7'h01;
		wt(3);
		chk({15'h0, irq}, 16'h0000);
		src = 7'h00;
		$display("test summary sources done");
		ovl = 1'b1;
		wt(6);
		rchk(psia_pkg::ADDR_LIVE, 16'h0004);
		rchk(psia_pkg::ADDR_LATCHED, 16'h0004);
		rchk(psia_pkg::ADDR_SUMMARY, 16'h0000);
		gie = 1'b1;
		wt(2);
		chk({15'h0, irq}, 16'h0000);
		psia_host_inst.wr(psia_pkg::ADDR_IRQ_EN, 16'hFFFF);
		rchk(psia_pkg::ADDR_IRQ_EN, psia_pkg::IE_MASK);
		rchk(psia_pkg::ADDR_SUMMARY, 16'h0200);
		chk({15'h0, irq}, 16'h0001);
		psia_host_inst.wr(psia_pkg::ADDR_LATCHED, 16'h0000);
		rchk(psia_pkg::ADDR_LATCHED, 16'h0004);
		psia_host_inst.wr(psia_pkg::ADDR_SUMMARY, 16'h0000);
		rchk(psia_pkg::ADDR_SUMMARY, 16'h0200);
		// overload still high: the level alone must not set the latch again
		psia_host_inst.wr(psia_pkg::ADDR_LATCHED, 16'hFFFF);
		rchk(psia_pkg::ADDR_LATCHED, 16'h0000);
		rchk(psia_pkg::ADDR_SUMMARY, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		ovl = 1'b0;
		lock = 1'b1;
		wt(6);
		rchk(psia_pkg::ADDR_LIVE, 16'h0002);
		rchk(psia_pkg::ADDR_LATCHED, 16'h0002);
		perf = 4'h7;
		wt(6);
		rchk(psia_pkg::ADDR_LIVE, 16'h0002);
		perf = 4'hF; // held until done reads high
		wt(6);
		rchk(psia_pkg::ADDR_LIVE, 16'h0003);
		rchk(psia_pkg::ADDR_LATCHED, 16'h0003);
		psia_host_inst.wr(psia_pkg::ADDR_LATCHED, 16'h0003);
		perf = 4'h0;
		lock = 1'b0;
		wt(6);
		rchk(psia_pkg::ADDR_LIVE, 16'h0000);
		$display("test live and latched done");
		for (int j = 0; j < 3; j++) begin
			for (int k = 0; k < 4; k++) begin
				clks[j] = ~clks[j];
				wt(4);
			end
			wt(4);
			rchk(psia_pkg::ADDR_LATCHED, (j == 2) ? 16'h0040 : 16'h0080);
			psia_host_inst.wr(psia_pkg::ADDR_LATCHED, 16'hFFFF);
		end
		rchk(psia_pkg::ADDR_LATCHED, 16'h0000);
		rchk(8'h60, 16'h0000);
		$display("test clock activity done");
		for (int j = 0; j < 3; j++) begin
			ctl = 3'h1 << j;
			wt(2);
			chk({15'h0, ptc}, 16'h0001);
			ctl = 3'h0;
			wt(2);
			chk({15'h0, ptc}, 16'h0000);
		end
		$display("test pattern tester clear done");
		end_of_test();
	end
	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		end_of_test();
	end
endmodule
